// [rtl/drv_serial_params.svh]
`ifndef DRV_SERIAL_PARAMS_SVH
`define DRV_SERIAL_PARAMS_SVH

`define WORD_BITS    16
`define FIFO_DEPTH   8
`define KEY_MSB      15
`define KEY_LSB      12
`define MODE_MSB     11
`define MODE_LSB     8
`define DATA_MSB     7
`define KEY_VALUE    4'hA
`define MODE_OUTPUT  4'hC
`define MODE_DIAG    4'h3
`define MODE_PROT    4'hA
`define CMD_RESET    8'h00
`define FAULT_RESET  16'h0000
`define FAULT_ALL    16'hFFFF
`define PIN_RESET    6'h02
`define DIRECT_LSB   5
`define CNT_LAST     4'hF
`define CNT_ZERO     4'h0

`endif

// [rtl/drv_serial_pkg.sv]
package drv_serial_pkg;
    // Frame tracking, one-hot
    typedef enum logic [1:0] {
        FR_IDLE  = 2'b01,
        FR_FRAME = 2'b10
    } frame_state_t;
endpackage : drv_serial_pkg

// [rtl/cmd_fifo.sv]
module cmd_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             CLK,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    // Pointer arithmetic needs a power of two
    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
            $error("cmd_fifo depth must be a power of two");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];   // Storage
    logic [AW:0]      wr_r, wr_nxt;  // Write pointer, wrap bit on top
    logic [AW:0]      rd_r, rd_nxt;  // Read pointer
    logic             push, pop;

    // Full when pointers differ only in wrap bit
    assign in_ready  = !((wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]));
    assign out_valid = (wr_r != rd_r);
    assign out_data  = mem[rd_r[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer next values
    always_comb begin
        wr_nxt = push ? wr_r + 1'b1 : wr_r;
        rd_nxt = pop ? rd_r + 1'b1 : rd_r;
    end

    // Pointer registers
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
        end
    end

    // Storage has no reset; empty flag hides stale words
    always_ff @(posedge CLK) begin
        if (push) begin
            mem[wr_r[AW-1:0]] <= in_data;
        end
    end
endmodule : cmd_fifo

// [rtl/octal_drv_serial.sv]
`include "drv_serial_params.svh"

module octal_drv_serial #(
    parameter int WORD_W = `WORD_BITS,
    parameter int DEPTH  = `FIFO_DEPTH
) (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        RESET_IN_N,
    input  wire logic        SCLK,
    input  wire logic        CS_N,
    input  wire logic        SERIAL_IN_PIN,
    output logic             SDO,
    output logic             SDO_OE,
    input  wire logic        DIRECT_ENABLE_CH6,
    input  wire logic        DIRECT_ENABLE_CH7,
    input  wire logic        DIRECT_ENABLE_CH8,
    input  wire logic [15:0] FAULT_SET,
    input  wire logic        THERMAL_ACTIVE,
    input  wire logic        APPLY_HOLD,
    output logic      [7:0]  CHANNEL_OUTPUTS,
    output logic      [7:0]  DIAG_LATCH,
    output logic      [7:0]  LINEAR_LIMIT,
    output logic             QUEUE_READY
);
    import drv_serial_pkg::*;

    // Word framing is fixed by the key and mode fields
    generate
        if (WORD_W != 16) begin : g_bad_word
            $error("octal_drv_serial serves 16-bit words only");
        end
    endgenerate

    // ---- Reset: async assert, sync release ----
    logic       rst_src_n;       // Either reset source low
    logic [1:0] rst_sync_r;      // Release synchroniser
    logic       rst_n_int;       // Internal reset, active low

    assign rst_src_n = RST_N & RESET_IN_N;
    assign rst_n_int = rst_sync_r[1];

    // Release delayed two clocks to avoid metastable exit
    always_ff @(posedge CLK or negedge rst_src_n) begin
        if (!rst_src_n) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    // ---- Pin synchronisers ----
    logic [5:0] pin_raw;         // EN8 EN7 EN6 DI CS SCLK
    logic [5:0] pin_s1_r;        // First stage, read only by second
    logic [5:0] pin_s2_r;        // Synchronised level
    logic [5:0] pin_d_r;         // Delayed copy for edge finding

    // Sync reset levels: select high, so no false frame edge after reset
    localparam logic [5:0] PIN_INIT = `PIN_RESET;

    assign pin_raw = {DIRECT_ENABLE_CH8, DIRECT_ENABLE_CH7, DIRECT_ENABLE_CH6,
                      SERIAL_IN_PIN, CS_N, SCLK};

    // Two flops per pin, then an edge copy
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_sync
            always_ff @(posedge CLK or negedge rst_n_int) begin
                if (!rst_n_int) begin
                    pin_s1_r[gi] <= PIN_INIT[gi];
                    pin_s2_r[gi] <= PIN_INIT[gi];
                    pin_d_r[gi]  <= PIN_INIT[gi];
                end else begin
                    pin_s1_r[gi] <= pin_raw[gi];
                    pin_s2_r[gi] <= pin_s1_r[gi];
                    pin_d_r[gi]  <= pin_s2_r[gi];
                end
            end
        end
    endgenerate

    logic       sclk_rise;       // Serial clock rising, one cycle
    logic       sclk_fall;       // Serial clock falling, one cycle
    logic       cs_fall;         // Frame start pulse
    logic       cs_rise;         // Frame end pulse
    logic       cs_low;          // Select asserted
    logic       di_s;            // Synchronised serial input
    logic [2:0] en_s;            // Synchronised discrete enables

    // SCLK at 160 ns leaves 16 system clocks per bit
    assign sclk_rise = pin_s2_r[0] & ~pin_d_r[0];
    assign sclk_fall = ~pin_s2_r[0] & pin_d_r[0];
    assign cs_fall   = ~pin_s2_r[1] & pin_d_r[1];
    assign cs_rise   = pin_s2_r[1] & ~pin_d_r[1];
    assign cs_low    = ~pin_s2_r[1];
    assign di_s      = pin_s2_r[2];
    assign en_s      = pin_s2_r[5:3];

    // ---- Frame receive and transmit ----
    frame_state_t st_r, st_nxt;          // Frame state
    logic [3:0]   cnt_r, cnt_nxt;        // Bits modulo sixteen
    logic         any_r, any_nxt;        // At least one bit clocked
    logic         done_r, done_nxt;      // First word complete
    logic [15:0]  rx_r, rx_nxt;          // Input shifter, LSB enters first
    logic [15:0]  first_r, first_nxt;    // First whole word of frame
    logic [15:0]  tx_r, tx_nxt;          // Output shifter
    logic [15:0]  fault_r, fault_nxt;    // Sticky fault bits
    logic         frame_ok;              // Whole words and good key
    logic         push_v;                // Offer word to queue
    logic         in_ready;              // Queue has room
    logic         key_ok;                // First word carries key

    assign key_ok   = (first_r[`KEY_MSB:`KEY_LSB] == `KEY_VALUE);
    assign frame_ok = (st_r == FR_FRAME) && (cnt_r == `CNT_ZERO)
                      && any_r && done_r && key_ok;
    assign push_v   = cs_rise && frame_ok;

    // Next state of frame logic
    always_comb begin
        st_nxt    = st_r;
        cnt_nxt   = cnt_r;
        any_nxt   = any_r;
        done_nxt  = done_r;
        rx_nxt    = rx_r;
        first_nxt = first_r;
        tx_nxt    = tx_r;
        case (st_r)
            FR_IDLE: begin
                // Select fall opens a frame and loads faults
                if (cs_fall) begin
                    st_nxt   = FR_FRAME;
                    cnt_nxt  = `CNT_ZERO;
                    any_nxt  = 1'b0;
                    done_nxt = 1'b0;
                    // Thermal shutdown reads as all faults set
                    tx_nxt   = THERMAL_ACTIVE ? `FAULT_ALL : fault_r;
                end
            end
            FR_FRAME: begin
                if (cs_rise) begin
                    // Partial word voids the whole frame: nothing queued, faults kept
                    st_nxt = FR_IDLE;
                end else if (sclk_rise && cs_low) begin
                    // Capture on rise, LSB arrives first
                    rx_nxt  = {di_s, rx_r[15:1]};
                    cnt_nxt = cnt_r + 4'h1;
                    any_nxt = 1'b1;
                    if (cnt_r == `CNT_LAST && !done_r) begin
                        first_nxt = {di_s, rx_r[15:1]};
                        done_nxt  = 1'b1;
                    end
                end else if (sclk_fall && cs_low) begin
                    // Shift out LSB first; last captured bit refills top
                    tx_nxt = {rx_r[15], tx_r[15:1]};
                end
            end
            default: begin
                st_nxt = FR_IDLE;
            end
        endcase
    end

    // Frame registers
    always_ff @(posedge CLK or negedge rst_n_int) begin
        if (!rst_n_int) begin
            st_r    <= FR_IDLE;
            cnt_r   <= `CNT_ZERO;
            any_r   <= 1'b0;
            done_r  <= 1'b0;
            rx_r    <= `FAULT_RESET;
            first_r <= `FAULT_RESET;
            tx_r    <= `FAULT_RESET;
        end else begin
            st_r    <= st_nxt;
            cnt_r   <= cnt_nxt;
            any_r   <= any_nxt;
            done_r  <= done_nxt;
            rx_r    <= rx_nxt;
            first_r <= first_nxt;
            tx_r    <= tx_nxt;
        end
    end

    // Serial output: value only from shifter, enable from select
    assign SDO    = tx_r[0];
    assign SDO_OE = cs_low;

    // ---- Fault register ----
    // New fault in the clearing cycle survives: set wins
    always_comb begin
        fault_nxt = (cs_rise && frame_ok) ? `FAULT_RESET : fault_r;
        fault_nxt = fault_nxt | FAULT_SET;
    end

    always_ff @(posedge CLK or negedge rst_n_int) begin
        if (!rst_n_int) begin
            fault_r <= `FAULT_RESET;
        end else begin
            fault_r <= fault_nxt;
        end
    end

    // ---- Command queue ----
    logic        q_valid;        // Word waiting
    logic        q_ready;        // Apply side accepts
    logic [15:0] q_data;         // Head word

    // Hold on the apply side lets the queue really fill
    assign q_ready     = !APPLY_HOLD;
    assign QUEUE_READY = in_ready;

    cmd_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .CLK       (CLK),
        .rst_n     (rst_n_int),
        .in_valid  (push_v),
        .in_ready  (in_ready),
        .in_data   (first_r),
        .out_valid (q_valid),
        .out_ready (q_ready),
        .out_data  (q_data)
    );

    // ---- Command registers ----
    logic [7:0] out_cmd_r, out_cmd_nxt;   // Serial on/off bits
    logic [7:0] diag_r, diag_nxt;         // Latch mode bits
    logic [7:0] lim_r, lim_nxt;           // Linear limit bits
    logic [7:0] ch_r, ch_nxt;             // Driven channel state
    logic [3:0] mode;                     // Head word writing mode
    logic       pop;                      // Head word applied

    assign mode = q_data[`MODE_MSB:`MODE_LSB];
    assign pop  = q_valid && q_ready;

    // Apply head word; unknown mode codes change nothing
    always_comb begin
        out_cmd_nxt = out_cmd_r;
        diag_nxt    = diag_r;
        lim_nxt     = lim_r;
        if (pop) begin
            if (mode == `MODE_OUTPUT) begin
                out_cmd_nxt = q_data[`DATA_MSB:0];
            end else if (mode == `MODE_DIAG) begin
                diag_nxt = q_data[`DATA_MSB:0];
            end else if (mode == `MODE_PROT) begin
                lim_nxt = q_data[`DATA_MSB:0];
            end
        end
        // Discrete pins ORed onto the upper three channels
        ch_nxt = out_cmd_r;
        ch_nxt[7:`DIRECT_LSB] = out_cmd_r[7:`DIRECT_LSB] | en_s;
    end

    always_ff @(posedge CLK or negedge rst_n_int) begin
        if (!rst_n_int) begin
            out_cmd_r <= `CMD_RESET;
            diag_r    <= `CMD_RESET;
            lim_r     <= `CMD_RESET;
            ch_r      <= `CMD_RESET;
        end else begin
            out_cmd_r <= out_cmd_nxt;
            diag_r    <= diag_nxt;
            lim_r     <= lim_nxt;
            ch_r      <= ch_nxt;
        end
    end

    assign CHANNEL_OUTPUTS = ch_r;
    assign DIAG_LATCH      = diag_r;
    assign LINEAR_LIMIT    = lim_r;

    // ---- Checks ----
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n_int);

    sequence s_frame_open;
        cs_fall && !THERMAL_ACTIVE && st_r == FR_IDLE;
    endsequence

    sequence s_frame_good_end;
        cs_rise && frame_ok;
    endsequence

    chk_pin_forces_on: assert property (en_s[0] |=> CHANNEL_OUTPUTS[5])
        else $error("discrete enable did not force channel on");
    chk_serial_or_pin: assert property (out_cmd_r[7] |=> CHANNEL_OUTPUTS[7])
        else $error("serial command lost on channel eight");
    chk_pin_low_off: assert property (
        !en_s[1] && !out_cmd_r[6] |=> !CHANNEL_OUTPUTS[6])
        else $error("channel seven on without a source");
    chk_reset_clears: assert property (
        @(posedge CLK) disable iff (1'b0) !rst_n_int |-> CHANNEL_OUTPUTS == 8'h00)
        else $error("channels on during reset");
    chk_sdo_hiz: assert property (SDO_OE |-> !$past(CS_N, 2))
        else $error("serial output driven with select high");
    chk_fault_first: assert property (
        s_frame_open |=> SDO == $past(fault_r[0]) ##1 SDO == $past(fault_r[0], 2))
        else $error("first output bit is not fault bit zero");
    chk_echo_feed: assert property (
        st_r == FR_FRAME && sclk_fall && cs_low && !cs_rise
        |=> tx_r[15] == $past(rx_r[15]))
        else $error("input bit not fed into echo path");
    chk_sdo_on_fall: assert property (
        !sclk_fall && !cs_fall |=> $stable(SDO))
        else $error("serial output changed without a clock fall");
    chk_fault_clear: assert property (
        s_frame_good_end |=> fault_r == $past(FAULT_SET))
        else $error("fault register not cleared after valid frame");
    chk_partial_drop: assert property (
        cs_rise && cnt_r != `CNT_ZERO |-> !push_v)
        else $error("partial word was queued");
    chk_key_gate: assert property (push_v |-> key_ok)
        else $error("word queued without key");
    chk_mode_out: assert property (
        pop && mode == `MODE_OUTPUT |=> out_cmd_r == $past(q_data[7:0]))
        else $error("output mode word not applied");
    // Mode codes, capture edge, frame gating, thermal reply and reset release
    chk_diag_apply: assert property (
        pop && mode == `MODE_DIAG |=> diag_r == $past(q_data[`DATA_MSB:0]))
        else $error("diagnostic mode word not applied");
    chk_lim_apply: assert property (
        pop && mode == `MODE_PROT |=> lim_r == $past(q_data[`DATA_MSB:0]))
        else $error("protection mode word not applied");
    chk_mode_unknown: assert property (
        pop && mode != `MODE_OUTPUT && mode != `MODE_DIAG && mode != `MODE_PROT
        |=> $stable(out_cmd_r) && $stable(diag_r) && $stable(lim_r))
        else $error("unknown writing mode changed a register");
    chk_capture_rise: assert property (
        st_r == FR_FRAME && sclk_rise && cs_low && !cs_rise
        |=> rx_r[`WORD_BITS-1] == $past(SERIAL_IN_PIN, 3))
        else $error("input bit not captured at clock rise");
    chk_in_frame_only: assert property (!cs_low |=> $stable(rx_r))
        else $error("input shifted with select high");
    chk_first_kept: assert property (done_r |=> $stable(first_r))
        else $error("later word overwrote the command word");
    chk_thermal_ones: assert property (
        cs_fall && THERMAL_ACTIVE && st_r == FR_IDLE |=> tx_r == `FAULT_ALL)
        else $error("thermal frame did not report all faults");
    chk_reset_release: assert property (
        $rose(rst_n_int) |-> $past(rst_src_n) && $past(rst_src_n, 2))
        else $error("internal reset released without two clean clocks");
endmodule : octal_drv_serial

// [dv/spi_host_model.sv]
// Host side of the serial link: mode 0, words leave LSB first
module spi_host_model (
    input  wire logic clk,
    input  wire logic so_line,
    output logic      sclk,
    output logic      cs_n,
    output logic      sdi
);
    timeunit 1ns;
    timeprecision 1ps;

    int half = 8;               // System clocks per link half period, 8 gives 80 ns and a 160 ns link period

    // Link idles deselected, clock low, data pulled up
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi  = 1'b1;
    end

    // One frame of nbits; the reply is sampled at each rising link edge
    task automatic frame(input logic [31:0] di, input int nbits, output logic [31:0] got);
        got = '0;
        @(posedge clk);
        cs_n <= 1'b0;
        repeat (2 * half) @(posedge clk);
        for (int i = 0; i < nbits; i++) begin
            sdi <= di[i];
            repeat (half) @(posedge clk);
            sclk <= 1'b1;
            got[i] = so_line;
            repeat (half) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (half) @(posedge clk);
        cs_n <= 1'b1;
        sdi  <= 1'b1;                       // Deselected line goes to its pull-up
        repeat (half) @(posedge clk);       // Gap keeps frames well apart
    endtask : frame
endmodule : spi_host_model

// [dv/tb_octal_driver_serial.sv]
module tb_octal_driver_serial_control;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0;
    logic        rst_n, res_n, sclk, cs_n, sdi, sdo, sdo_oe, qrdy, thermal, hold;
    logic        float_r = 1'b0;        // Stands in for a floating output line
    logic [2:0]  pins;                  // Discrete enables, bit0 = channel six
    logic [15:0] fault_set, w;
    logic [7:0]  ch_out, diag, lin, exp_out, exp_diag, exp_lin;
    logic [31:0] got;
    int          failures = 0;
    int          checks = 0;
    // Released output shows a level that changes every cycle
    wire         so_line = sdo_oe ? sdo : float_r;

    always #5 clk = ~clk;
    always @(posedge clk) float_r <= ~float_r;

    octal_drv_serial dut_u (
        .CLK(clk), .RST_N(rst_n), .RESET_IN_N(res_n), .SCLK(sclk), .CS_N(cs_n),
        .SERIAL_IN_PIN(sdi), .SDO(sdo), .SDO_OE(sdo_oe), .DIRECT_ENABLE_CH6(pins[0]),
        .DIRECT_ENABLE_CH7(pins[1]), .DIRECT_ENABLE_CH8(pins[2]), .FAULT_SET(fault_set),
        .THERMAL_ACTIVE(thermal), .APPLY_HOLD(hold), .CHANNEL_OUTPUTS(ch_out),
        .DIAG_LATCH(diag), .LINEAR_LIMIT(lin), .QUEUE_READY(qrdy)
    );

    spi_host_model host_u (.clk(clk), .so_line(so_line), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));

    // Verdict in one place
    task automatic conclude;
        if (failures == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask : cycles

    // Channel view is the command ORed with the discrete pins
    task automatic regs_check;
        check({8'h00, ch_out, diag, lin}, {8'h00, exp_out | {pins, 5'h00}, exp_diag, exp_lin});
    endtask : regs_check

    // Frame, then reply and settled registers
    task automatic frame_chk(input logic [31:0] di, input int n, input logic [15:0] ef);
        host_u.frame(di, n, got);
        check({16'h0000, got[15:0]}, {16'h0000, ef});
        if (n == 32) check({16'h0000, got[31:16]}, {16'h0000, di[15:0]});
        cycles(8);
        regs_check();
        check({31'h0, sdo_oe}, 32'h0);
    endtask : frame_chk

    task automatic pulse_fault(input logic [15:0] p);
        fault_set <= p;
        cycles(1);
        fault_set <= 16'h0000;
        cycles(2);
    endtask : pulse_fault

    // Watchdog well beyond the expected run
    initial begin
        #600000;
        failures++;
        conclude();
    end

    initial begin
        rst_n = 1'b0; res_n = 1'b1; pins = 3'h0; fault_set = 16'h0000;
        thermal = 1'b0; hold = 1'b0;
        exp_out = 8'h00; exp_diag = 8'h00; exp_lin = 8'h00;
        cycles(6);
        rst_n <= 1'b1;
        cycles(10);
        regs_check();
        check({30'h0, sdo_oe, qrdy}, 32'h1);
        // Each writing mode with fresh faults and a chained second word
        for (int i = 0; i < 3; i++) begin
            pulse_fault(16'hA50F ^ 16'(i));
            w[7:0] = 8'(8'h69 + 8'h11 * i);
            w[15:8] = (i == 0) ? 8'hAC : (i == 1) ? 8'hA3 : 8'hAA;
            case (i)
                0: exp_out = w[7:0];
                1: exp_diag = w[7:0];
                default: exp_lin = w[7:0];
            endcase
            frame_chk({16'h3C5A ^ 16'(i), w}, 32, 16'hA50F ^ 16'(i));
        end
        // Refused frames keep faults and registers; the last, an unknown mode, is accepted and clears faults
        pulse_fault(16'h0042);
        frame_chk({16'h0000, 16'h5CFF}, 16, 16'h0042);
        frame_chk({16'h0000, 16'hACFF}, 20, 16'h0042);
        frame_chk({16'h0000, 16'hACFF}, 8, 16'h0042);
        frame_chk({16'h0000, 16'hA5FF}, 16, 16'h0042);
        // Thermal at frame open, slow host
        thermal <= 1'b1;
        host_u.half = 12;
        exp_out = 8'hA0;
        frame_chk({16'h0000, 16'hACA0}, 16, 16'hFFFF);
        thermal <= 1'b0;
        host_u.half = 8;
        frame_chk({16'h0000, 16'hACA0}, 16, 16'h0000);
        // Every pin combination against a mixed command
        for (int p = 0; p < 8; p++) begin
            pins <= 3'(p);
            cycles(5);
            regs_check();
        end
        // Device reset pin clears at once
        pins <= 3'h0;
        res_n <= 1'b0;
        exp_out = 8'h00; exp_diag = 8'h00; exp_lin = 8'h00;
        cycles(1);
        #1;
        regs_check();
        check({31'h0, sdo_oe}, 32'h0);
        cycles(1);
        res_n <= 1'b1;
        cycles(10);
        // Queue fills while applying is held, ninth word lost
        hold <= 1'b1;
        for (int k = 1; k <= 9; k++) begin
            frame_chk({16'h0000, 8'hAC, 8'(k)}, 16, 16'h0000);
            if (k == 8) check({31'h0, qrdy}, 32'h0);
        end
        hold <= 1'b0;
        cycles(20);
        exp_out = 8'h08;
        regs_check();
        check({31'h0, qrdy}, 32'h1);
        conclude();
    end
endmodule : tb_octal_driver_serial_control
